/* pkg/pesc_pkg.sv */
// shared constants and bus carrier for the power event status collector
package pesc_pkg;

    localparam int DATA_W         = 32;
    localparam int ADDR_W         = 12;
    localparam int UNITS_PER_WORD = 32;
    localparam int MAX_WORDS      = 4;
    localparam int SEL_LSB        = 2;
    localparam int SEL_W          = 2;
    localparam int BANK_LSB       = 4;

    // each bank of words spans 16 bytes, word select in addr[3:2]
    localparam logic [ADDR_W-1:0] OFS_CORE_PWR    = 12'h0b20;
    localparam logic [ADDR_W-1:0] OFS_CLUSTER_PWR = 12'h0b40;
    localparam logic [ADDR_W-1:0] OFS_LOCK_EV     = 12'h0b80;
    localparam logic [ADDR_W-1:0] OFS_LOCK_MASK   = 12'h0b90;
    localparam logic [ADDR_W-1:0] OFS_UNLOCK_EV   = 12'h0bc0;
    localparam logic [ADDR_W-1:0] OFS_UNLOCK_MASK = 12'h0bd0;
    localparam logic [ADDR_W-1:0] OFS_FABRIC      = 12'h0c00;

    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
    localparam logic [DATA_W-1:0] MASK_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } pesc_bus_req_s;

endpackage

/* verilog/pesc_sync.sv */
// two-flop synchroniser for a bus of independent level inputs
`timescale 1ns/10ps
module pesc_sync #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pesc_sync_state_s;

    pesc_sync_state_s state;
    pesc_sync_state_s next_state;

    if (WIDTH < 1) begin : g_chk
        $error("pesc_sync: WIDTH must be at least 1");
    end

    always_comb begin
        next_state.meta   = async_in;
        next_state.stable = state.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stable;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_sync_two_cycles: assert property (
        (!$past(reset) && !$past(reset, 2)) |-> sync_out == $past(async_in, 2))
        else $error("synchroniser output is not the input two cycles earlier");
endmodule

/* verilog/pesc_edge_bank.sv */
// sticky lock and unlock event bits with write-one-to-clear
`timescale 1ns/10ps
module pesc_edge_bank #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // synchronised lock levels
    input  wire logic [WIDTH-1:0] lock_lvl,
    // software clears, one per bit
    input  wire logic [WIDTH-1:0] lock_clr,
    input  wire logic [WIDTH-1:0] unlock_clr,
    // sticky events
    output logic      [WIDTH-1:0] lock_events,
    output logic      [WIDTH-1:0] unlock_events
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] lock;
        logic [WIDTH-1:0] unlock;
    } pesc_bank_state_s;

    pesc_bank_state_s state;
    pesc_bank_state_s next_state;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;

    if (WIDTH < 1) begin : g_chk
        $error("pesc_edge_bank: WIDTH must be at least 1");
    end

    assign rise = lock_lvl & ~state.prev;
    assign fall = ~lock_lvl & state.prev;

    // a new edge wins over a clear in the same cycle
    always_comb begin
        next_state.prev   = lock_lvl;
        next_state.lock   = (state.lock & ~lock_clr) | rise;
        next_state.unlock = (state.unlock & ~unlock_clr) | fall;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign lock_events   = state.lock;
    assign unlock_events = state.unlock;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_lock_rise_sets: assert property ($rose(lock_lvl[0]) |=> lock_events[0])
        else $error("lock edge did not set the lock event");
    a_unlock_fall_sets: assert property ($fell(lock_lvl[0]) |=> unlock_events[0])
        else $error("unlock edge did not set the unlock event");
    a_w1c_clears_bit: assert property (
        (lock_clr[0] && !rise[0]) |=> !lock_events[0])
        else $error("write one did not clear the lock event");
    a_zero_write_keeps: assert property (
        (unlock_events[0] && !unlock_clr[0]) |=> unlock_events[0])
        else $error("unlock event lost without a clear");
    a_set_beats_clear: assert property (
        (lock_clr[0] && rise[0]) |=> lock_events[0])
        else $error("edge lost against a coincident clear");

    c_lock_event: cover property ($rose(lock_events[0]));
    c_set_and_clear: cover property (unlock_clr[0] && fall[0]);
endmodule

/* verilog/pesc_top.sv */
// status collector for power-policy, fabric and pll lock events
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
// Notes on behaviour
// - core power-policy status bits show live levels, read-only, reset to zero
// - core power words: word 0 holds cores 0..31, each next word 32 more
// - bit n of word x belongs to unit x*32+n, all 32 bits used
// - every status word exists only in the control processor build
// - cluster power-policy status bits show live levels, read-only, reset to zero
// - cluster power words: word 0 holds clusters 0..31, then 32 more each
// - a rising pll lock sets the sticky lock event bit
// - a falling pll lock sets the sticky unlock event bit
// - writing one clears an event bit, writing zero leaves it
// - lock event words: word 0 holds cores 0..31, then 32 more each
// - unlock event words: word 0 holds cores 0..31, then 32 more each
// - fabric interrupt words show live cluster levels, grouped 32 per word
module pesc_top
    import pesc_pkg::*;
#(
    parameter int NUM_WORDS  = 4,
    parameter bit SCP_CONFIG = 1'b1
) (
    // clock and reset
    input  wire logic                                       ref_clk,
    input  wire logic                                       reset,
    // register port
    input  wire pesc_pkg::pesc_bus_req_s                    bus_req,
    output logic      [pesc_pkg::DATA_W-1:0]                rd_data,
    // unit levels, bit i belongs to unit i
    input  wire logic [NUM_WORDS*pesc_pkg::UNITS_PER_WORD-1:0] core_power_irq_lvl,
    input  wire logic [NUM_WORDS*pesc_pkg::UNITS_PER_WORD-1:0] cluster_power_irq_lvl,
    input  wire logic [NUM_WORDS*pesc_pkg::UNITS_PER_WORD-1:0] core_pll_lock_lvl,
    input  wire logic [NUM_WORDS*pesc_pkg::UNITS_PER_WORD-1:0] cluster_fabric_irq_lvl,
    // interrupt
    output logic                                            irq_out
);
    import pesc_pkg::*;

    localparam int NB = NUM_WORDS * UNITS_PER_WORD;

    typedef logic [NUM_WORDS-1:0][DATA_W-1:0] pesc_bank_t;

    typedef struct packed {
        pesc_bank_t        lock_mask;
        pesc_bank_t        unlock_mask;
        logic [DATA_W-1:0] rd_data;
    } pesc_top_state_s;

    pesc_top_state_s   state;
    pesc_top_state_s   next_state;
    logic [NB-1:0]     core_pwr_sync;
    logic [NB-1:0]     cluster_pwr_sync;
    logic [NB-1:0]     lock_sync;
    logic [NB-1:0]     fabric_sync;
    logic [NB-1:0]     lock_gated;
    logic [NB-1:0]     lock_clr;
    logic [NB-1:0]     unlock_clr;
    logic [NB-1:0]     lock_events;
    logic [NB-1:0]     unlock_events;
    logic [NB-1:0]     lock_mask_flat;
    logic [NB-1:0]     unlock_mask_flat;
    logic [SEL_W-1:0]  sel;

    if (NUM_WORDS < 1 || NUM_WORDS > MAX_WORDS) begin : g_chk
        $error("pesc_top: NUM_WORDS must lie between 1 and MAX_WORDS");
    end

    // every level crosses two flops before it is sampled or edge-checked
    pesc_sync #(
        .WIDTH (NB)
    ) u_sync_core_pwr (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (core_power_irq_lvl),
        .sync_out (core_pwr_sync)
    );

    pesc_sync #(
        .WIDTH (NB)
    ) u_sync_cluster_pwr (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (cluster_power_irq_lvl),
        .sync_out (cluster_pwr_sync)
    );

    pesc_sync #(
        .WIDTH (NB)
    ) u_sync_lock (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (core_pll_lock_lvl),
        .sync_out (lock_sync)
    );

    pesc_sync #(
        .WIDTH (NB)
    ) u_sync_fabric (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (cluster_fabric_irq_lvl),
        .sync_out (fabric_sync)
    );

    // outside the control processor build the event bank sees a constant
    // level, so synthesis strips it together with the read paths
    assign lock_gated = SCP_CONFIG ? lock_sync : '0;

    pesc_edge_bank #(
        .WIDTH (NB)
    ) u_edge_bank (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .lock_lvl      (lock_gated),
        .lock_clr      (lock_clr),
        .unlock_clr    (unlock_clr),
        .lock_events   (lock_events),
        .unlock_events (unlock_events)
    );

    assign sel = bus_req.addr[BANK_LSB-1:SEL_LSB];

    function automatic logic in_bank(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] base
    );
        logic [SEL_W-1:0] s;
        s = a[BANK_LSB-1:SEL_LSB];
        return SCP_CONFIG
            && (a[ADDR_W-1:BANK_LSB] == base[ADDR_W-1:BANK_LSB])
            && (a[SEL_LSB-1:0] == '0)
            && (int'(s) < NUM_WORDS);
    endfunction

    // word x of a bank is bits x*32 .. x*32+31 of the unit vector
    function automatic logic [DATA_W-1:0] pick(
        input logic [NB-1:0]    v,
        input logic [SEL_W-1:0] s
    );
        return v[int'(s)*DATA_W +: DATA_W];
    endfunction

    always_comb begin
        next_state         = state;
        next_state.rd_data = RESET_WORD;
        lock_clr           = '0;
        unlock_clr         = '0;
        // only event and mask words decode writes; status words ignore them
        if (bus_req.wr) begin
            if (in_bank(bus_req.addr, OFS_LOCK_EV)) begin
                lock_clr[int'(sel)*DATA_W +: DATA_W] = bus_req.wdata;
            end else if (in_bank(bus_req.addr, OFS_UNLOCK_EV)) begin
                unlock_clr[int'(sel)*DATA_W +: DATA_W] = bus_req.wdata;
            end else if (in_bank(bus_req.addr, OFS_LOCK_MASK)) begin
                next_state.lock_mask[sel] = bus_req.wdata;
            end else if (in_bank(bus_req.addr, OFS_UNLOCK_MASK)) begin
                next_state.unlock_mask[sel] = bus_req.wdata;
            end
        end
        // unmapped reads answer zero
        if (bus_req.rd) begin
            if (in_bank(bus_req.addr, OFS_CORE_PWR)) begin
                next_state.rd_data = pick(core_pwr_sync, sel);
            end else if (in_bank(bus_req.addr, OFS_CLUSTER_PWR)) begin
                next_state.rd_data = pick(cluster_pwr_sync, sel);
            end else if (in_bank(bus_req.addr, OFS_LOCK_EV)) begin
                next_state.rd_data = pick(lock_events, sel);
            end else if (in_bank(bus_req.addr, OFS_UNLOCK_EV)) begin
                next_state.rd_data = pick(unlock_events, sel);
            end else if (in_bank(bus_req.addr, OFS_LOCK_MASK)) begin
                next_state.rd_data = state.lock_mask[sel];
            end else if (in_bank(bus_req.addr, OFS_UNLOCK_MASK)) begin
                next_state.rd_data = state.unlock_mask[sel];
            end else if (in_bank(bus_req.addr, OFS_FABRIC)) begin
                next_state.rd_data = pick(fabric_sync, sel);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state.lock_mask   <= {NUM_WORDS{MASK_RESET}};
            state.unlock_mask <= {NUM_WORDS{MASK_RESET}};
            state.rd_data     <= RESET_WORD;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data          = state.rd_data;
    assign lock_mask_flat   = state.lock_mask;
    assign unlock_mask_flat = state.unlock_mask;
    // mask bit one lets the matching sticky event raise the interrupt
    assign irq_out = |(lock_events & lock_mask_flat)
                   | |(unlock_events & unlock_mask_flat);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_idle_read_zero: assert property (!bus_req.rd |=> rd_data == RESET_WORD)
        else $error("read data not zero outside the answer cycle");
    a_core_level_read: assert property (
        (bus_req.rd && bus_req.addr == OFS_CORE_PWR)
            |=> rd_data == (SCP_CONFIG ? $past(core_pwr_sync[DATA_W-1:0]) : RESET_WORD))
        else $error("core power word 0 does not show the live levels");
    a_cluster_level_read: assert property (
        (bus_req.rd && bus_req.addr == OFS_CLUSTER_PWR)
            |=> rd_data == (SCP_CONFIG ? $past(cluster_pwr_sync[DATA_W-1:0]) : RESET_WORD))
        else $error("cluster power word 0 does not show the live levels");
    a_fabric_read: assert property (
        (bus_req.rd && bus_req.addr == OFS_FABRIC)
            |=> rd_data == (SCP_CONFIG ? $past(fabric_sync[DATA_W-1:0]) : RESET_WORD))
        else $error("fabric word 0 does not show the live levels");
    a_lock_word_read: assert property (
        (bus_req.rd && bus_req.addr == OFS_LOCK_EV)
            |=> rd_data == $past(lock_events[DATA_W-1:0]))
        else $error("lock event word 0 reads wrong");
    a_irq_from_event: assert property (
        (SCP_CONFIG && $rose(lock_sync[0]) && state.lock_mask[0][0]
            && !(bus_req.wr && bus_req.addr == OFS_LOCK_MASK)) |=> irq_out)
        else $error("unmasked lock event did not raise the interrupt");
    a_ro_write_inert: assert property (
        (bus_req.wr && (bus_req.addr == OFS_CORE_PWR || bus_req.addr == OFS_FABRIC))
            |-> (lock_clr == '0 && unlock_clr == '0))
        else $error("write to a read-only word touched the event bits");

    c_irq_rises: cover property ($rose(irq_out));
    c_unlock_read: cover property (bus_req.rd && bus_req.addr == OFS_UNLOCK_EV
        ##1 rd_data != RESET_WORD);
    c_clear_lock: cover property (bus_req.wr && bus_req.addr == OFS_LOCK_EV
        && bus_req.wdata != RESET_WORD);
endmodule

/* dv/pesc_unit_model.sv */
// far-side units: power-policy, fabric and pll lock levels
`timescale 1ns/10ps
module pesc_unit_model #(
    parameter int WIDTH = 128
) (
    // clock
    input  wire logic             ref_clk,
    // levels the bench asks for
    input  wire logic [WIDTH-1:0] core_pwr_req,
    input  wire logic [WIDTH-1:0] clus_pwr_req,
    input  wire logic [WIDTH-1:0] lock_req,
    input  wire logic [WIDTH-1:0] fabric_req,
    // levels at the collector pins
    output logic      [WIDTH-1:0] core_pwr_lvl = '0,
    output logic      [WIDTH-1:0] clus_pwr_lvl = '0,
    output logic      [WIDTH-1:0] lock_lvl     = '0,
    output logic      [WIDTH-1:0] fabric_lvl   = '0
);
    // real units switch from their own flops, so levels only move after an edge
    always @(posedge ref_clk) begin
        core_pwr_lvl <= core_pwr_req;
        clus_pwr_lvl <= clus_pwr_req;
        lock_lvl     <= lock_req;
        fabric_lvl   <= fabric_req;
    end
endmodule

/* dv/power_event_status_collector_tb_top.sv */
// self-checking bench for the power event status collector
`timescale 1ns/10ps
module power_event_status_collector_tb_top;
    import pesc_pkg::*;

    localparam int NW = 4;
    localparam int UW = NW * UNITS_PER_WORD;

    logic              ref_clk = 1'b0;
    logic              reset   = 1'b1;
    pesc_bus_req_s     bus_req = '0;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] rd_data_off;
    logic              irq_out;
    logic              irq_off;
    logic [UW-1:0]     core_t = '0;
    logic [UW-1:0]     clus_t = '0;
    logic [UW-1:0]     lock_t = '0;
    logic [UW-1:0]     fab_t  = '0;
    logic [UW-1:0]     core_l;
    logic [UW-1:0]     clus_l;
    logic [UW-1:0]     lock_l;
    logic [UW-1:0]     fab_l;
    logic [UW-1:0]     pat;
    logic [DATA_W-1:0] clr;
    int                miscompares = 0;
    int                checked     = 0;
    int                cycles      = 0;

    always #10 ref_clk = ~ref_clk;

    pesc_unit_model #(.WIDTH(UW)) u_pesc_unit_model (
        .ref_clk(ref_clk), .core_pwr_req(core_t), .clus_pwr_req(clus_t),
        .lock_req(lock_t), .fabric_req(fab_t), .core_pwr_lvl(core_l),
        .clus_pwr_lvl(clus_l), .lock_lvl(lock_l), .fabric_lvl(fab_l));

    pesc_top #(.NUM_WORDS(NW), .SCP_CONFIG(1'b1)) u_pesc_top (
        .ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
        .core_power_irq_lvl(core_l), .cluster_power_irq_lvl(clus_l),
        .core_pll_lock_lvl(lock_l), .cluster_fabric_irq_lvl(fab_l), .irq_out(irq_out));

    // same traffic into a build without the control processor option
    pesc_top #(.NUM_WORDS(NW), .SCP_CONFIG(1'b0)) u_pesc_top_off (
        .ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data_off),
        .core_power_irq_lvl(core_l), .cluster_power_irq_lvl(clus_l),
        .core_pll_lock_lvl(lock_l), .cluster_fabric_irq_lvl(fab_l), .irq_out(irq_off));

    function automatic logic [DATA_W-1:0] word_of(input logic [UW-1:0] v, input int x);
        return v[x*DATA_W +: DATA_W];
    endfunction

    function automatic logic [ADDR_W-1:0] wa(input logic [ADDR_W-1:0] b, input int x);
        return b + ADDR_W'(4 * x);
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic bus_rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        check(rd_data, exp);
        check(rd_data_off, '0);
    endtask

    task automatic irq_chk(input logic exp);
        #1;
        check({31'h0, irq_out}, {31'h0, exp});
        check({31'h0, irq_off}, 32'h0);
    endtask

    // two synchroniser flops plus the edge flop, with margin
    task automatic settle();
        repeat (6) @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        void'($urandom(48));
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        for (int x = 0; x < NW; x++) begin
            bus_rd_chk(wa(OFS_CORE_PWR, x), RESET_WORD);
            bus_rd_chk(wa(OFS_CLUSTER_PWR, x), RESET_WORD);
            bus_rd_chk(wa(OFS_LOCK_EV, x), RESET_WORD);
            bus_rd_chk(wa(OFS_UNLOCK_EV, x), RESET_WORD);
            bus_rd_chk(wa(OFS_LOCK_MASK, x), MASK_RESET);
            bus_rd_chk(wa(OFS_UNLOCK_MASK, x), MASK_RESET);
            bus_rd_chk(wa(OFS_FABRIC, x), RESET_WORD);
        end
        $display("test reset_values done");
        for (int r = 0; r < 5; r++) begin
            pat = (r == 0) ? '1 : (r == 1) ? '0 : {$urandom, $urandom, $urandom, $urandom};
            core_t <= pat;
            clus_t <= ~pat;
            fab_t  <= pat ^ {NW{32'h5a5a_a5a5}};
            settle();
            for (int x = 0; x < NW; x++) begin
                bus_wr(wa(OFS_CORE_PWR, x), $urandom);
                bus_wr(wa(OFS_FABRIC, x), $urandom);
                bus_rd_chk(wa(OFS_CORE_PWR, x), word_of(pat, x));
                bus_rd_chk(wa(OFS_CLUSTER_PWR, x), word_of(~pat, x));
                bus_rd_chk(wa(OFS_FABRIC, x), word_of(pat, x) ^ 32'h5a5a_a5a5);
            end
        end
        bus_rd_chk(OFS_CORE_PWR + 12'h1, 32'h0);
        bus_rd_chk(12'hb30, 32'h0);
        bus_rd_chk(12'hffc, 32'h0);
        $display("test live_levels done");
        pat = {$urandom, $urandom, $urandom, $urandom} | {1'b1, {(UW-2){1'b0}}, 1'b1};
        lock_t <= pat;
        settle();
        irq_chk(1'b0);
        for (int x = 0; x < NW; x++) begin
            bus_rd_chk(wa(OFS_LOCK_EV, x), word_of(pat, x));
            bus_rd_chk(wa(OFS_UNLOCK_EV, x), 32'h0);
        end
        lock_t <= '0;
        settle();
        for (int x = 0; x < NW; x++) begin
            clr = $urandom;
            bus_rd_chk(wa(OFS_UNLOCK_EV, x), word_of(pat, x));
            bus_wr(wa(OFS_LOCK_EV, x), clr);
            bus_rd_chk(wa(OFS_LOCK_EV, x), word_of(pat, x) & ~clr);
            bus_wr(wa(OFS_LOCK_EV, x), 32'hffff_ffff);
            bus_wr(wa(OFS_UNLOCK_EV, x), 32'hffff_ffff);
            bus_rd_chk(wa(OFS_UNLOCK_EV, x), 32'h0);
        end
        $display("test lock_events done");
        lock_t[37] <= 1'b1;
        settle();
        irq_chk(1'b0);
        bus_wr(wa(OFS_LOCK_MASK, 1), 32'h0000_0020);
        irq_chk(1'b1);
        bus_rd_chk(wa(OFS_LOCK_MASK, 1), 32'h0000_0020);
        bus_wr(wa(OFS_LOCK_EV, 1), 32'h0000_0020);
        irq_chk(1'b0);
        lock_t[37] <= 1'b0;
        settle();
        irq_chk(1'b0);
        bus_wr(wa(OFS_UNLOCK_MASK, 1), 32'hffff_ffff);
        irq_chk(1'b1);
        bus_wr(wa(OFS_UNLOCK_MASK, 1), 32'hffff_ffdf);
        irq_chk(1'b0);
        $display("test interrupt done");
        // unlock event 37 and both masks of word 1 are still set here
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        bus_rd_chk(wa(OFS_UNLOCK_EV, 1), RESET_WORD);
        bus_rd_chk(wa(OFS_LOCK_MASK, 1), MASK_RESET);
        bus_rd_chk(wa(OFS_UNLOCK_MASK, 1), MASK_RESET);
        irq_chk(1'b0);
        $display("test mid_reset done");
        // mask in unit 0 so the interrupt path sees every collision edge
        bus_wr(OFS_LOCK_MASK, 32'h0000_0001);
        // the pin change sets the bit four edges after lock_t moves, and a
        // write issued after d-1 edges lands on edge d+1: d = 3 collides
        for (int d = 2; d <= 6; d++) begin
            lock_t[0] <= 1'b0;
            settle();
            bus_wr(OFS_LOCK_EV, 32'hffff_ffff);
            bus_wr(OFS_UNLOCK_EV, 32'hffff_ffff);
            @(posedge ref_clk);
            lock_t[0] <= 1'b1;
            repeat (d - 1) @(posedge ref_clk);
            bus_wr(OFS_LOCK_EV, 32'h0000_0001);
            settle();
            bus_rd_chk(OFS_LOCK_EV, {31'h0, d <= 3});
        end
        $display("test clear_collision done");
        summarize();
    end
endmodule
